/* hw/eif_pkg.sv */
// Package with the register map, field layout and bus carrier of the external interrupt flags
package eif_pkg;

    localparam int EIF_ADDR_W      = 4;
    localparam int EIF_DATA_W      = 8;
    localparam int EIF_NUM_CH      = 2;
    localparam int EIF_SYNC_STAGES = 2;

    // Register offsets
    localparam logic [EIF_ADDR_W-1:0] EIF_TCTL_OFS = 4'h0;
    localparam logic [EIF_ADDR_W-1:0] EIF_CFG_OFS  = 4'h1;
    localparam logic [EIF_ADDR_W-1:0] EIF_STAT_OFS = 4'h2;
    localparam logic [EIF_ADDR_W-1:0] EIF_MASK_OFS = 4'h3;

    // Field positions in timer_and_interrupt_control
    localparam int EIF_SEL0_POS  = 0;
    localparam int EIF_PEND0_POS = 1;
    localparam int EIF_SEL1_POS  = 2;
    localparam int EIF_PEND1_POS = 3;

    // Field positions in ext_irq_config_reg, status and mask
    localparam int EIF_POL0_POS = 0;
    localparam int EIF_POL1_POS = 1;
    localparam int EIF_EV0_POS  = 0;
    localparam int EIF_EV1_POS  = 1;

    // Reset values
    localparam logic [EIF_DATA_W-1:0] EIF_TCTL_RST = 8'h00;
    localparam logic [EIF_DATA_W-1:0] EIF_CFG_RST  = 8'h00;
    localparam logic [EIF_DATA_W-1:0] EIF_STAT_RST = 8'h00;
    localparam logic [EIF_DATA_W-1:0] EIF_MASK_RST = 8'h00;
    localparam logic [EIF_DATA_W-1:0] EIF_RD_IDLE  = 8'h00;

    typedef struct packed {
        logic [EIF_ADDR_W-1:0] addr;
        logic [EIF_DATA_W-1:0] wdata;
        logic                  wr;
        logic                  rd;
    } eif_bus_req_t;

endpackage

/* hw/eif_sync_edge.sv */
// Input synchroniser with polarity and rising-activity detection for one channel
`timescale 1ns/1ps
`default_nettype none
module eif_sync_edge #(
    parameter int STAGES = 2
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic raw_in,
    input  wire logic polarity,
    output logic      active,
    output logic      rise
);

    logic [STAGES-1:0] sync_reg;
    logic              act_reg;
    logic              prev_reg;
    logic              act_next;

    if (STAGES < 2) begin : g_chk
        $error("eif_sync_edge needs at least two stages");
    end

    // Idle high keeps the default active-low input quiet after reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_reg <= '1;
        end else begin
            sync_reg <= {sync_reg[STAGES-2:0], raw_in};
        end
    end

    // Polarity 1 means active high, 0 active low
    assign act_next = polarity ? sync_reg[STAGES-1] : ~sync_reg[STAGES-1];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            act_reg  <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            act_reg  <= act_next;
            prev_reg <= act_reg;
        end
    end

    assign active = act_reg;
    // A polarity change while the pin idles may look like activity
    assign rise   = act_reg & ~prev_reg;

endmodule // eif_sync_edge
`default_nettype wire

/* hw/eif_top.sv */
// External interrupt flags: trigger select, pending flags, register port and interrupt output
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module eif_top
    import eif_pkg::*;
#(
    parameter int SYNC_STAGES = EIF_SYNC_STAGES
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire eif_bus_req_t          bus_req,
    output logic [EIF_DATA_W-1:0]      rd_data,
    input  wire logic                  ext_irq0_input,
    input  wire logic                  ext_irq1_input,
    input  wire logic                  vector_ack0,
    input  wire logic                  vector_ack1,
    output logic                       ext_irq0_pending,
    output logic                       ext_irq1_pending,
    output logic                       irq
);

    if (SYNC_STAGES < 2) begin : g_chk
        $error("eif_top needs SYNC_STAGES of at least two");
    end

    logic [EIF_NUM_CH-1:0] edge_sel_reg;
    logic [EIF_NUM_CH-1:0] edge_sel_next;
    logic [EIF_NUM_CH-1:0] pend_reg;
    logic [EIF_NUM_CH-1:0] pend_next;
    logic [EIF_NUM_CH-1:0] pol_reg;
    logic [EIF_NUM_CH-1:0] pol_next;
    logic [EIF_NUM_CH-1:0] stat_reg;
    logic [EIF_NUM_CH-1:0] stat_next;
    logic [EIF_NUM_CH-1:0] mask_reg;
    logic [EIF_NUM_CH-1:0] mask_next;
    logic [EIF_DATA_W-1:0] rd_data_reg;
    logic [EIF_DATA_W-1:0] rd_data_next;
    logic                  irq_reg;
    logic                  irq_next;

    logic [EIF_NUM_CH-1:0] raw_in;
    logic [EIF_NUM_CH-1:0] vec_ack;
    logic [EIF_NUM_CH-1:0] act;
    logic [EIF_NUM_CH-1:0] rise;
    logic [EIF_NUM_CH-1:0] wr_pend_val;
    logic [EIF_NUM_CH-1:0] wr_sel_val;
    logic [EIF_NUM_CH-1:0] wr_pol_val;
    logic [EIF_NUM_CH-1:0] wr_ev_val;
    logic [EIF_NUM_CH-1:0] pend_edge;
    logic [EIF_NUM_CH-1:0] pend_clr;
    logic [EIF_NUM_CH-1:0] pend_ev;
    logic [EIF_NUM_CH-1:0] stat_clr;

    logic                  wr_tctl;
    logic                  wr_cfg;
    logic                  wr_stat;
    logic                  wr_mask;
    logic                  sel_tctl;
    logic                  sel_cfg;
    logic                  sel_stat;
    logic                  sel_mask;
    logic [EIF_DATA_W-1:0] tctl_view;
    logic [EIF_DATA_W-1:0] cfg_view;
    logic [EIF_DATA_W-1:0] stat_view;
    logic [EIF_DATA_W-1:0] mask_view;
    logic [EIF_DATA_W-1:0] rd_mux;

    assign raw_in  = {ext_irq1_input, ext_irq0_input};
    assign vec_ack = {vector_ack1, vector_ack0};

    // Address decode
    assign sel_tctl = (bus_req.addr == EIF_TCTL_OFS);
    assign sel_cfg  = (bus_req.addr == EIF_CFG_OFS);
    assign sel_stat = (bus_req.addr == EIF_STAT_OFS);
    assign sel_mask = (bus_req.addr == EIF_MASK_OFS);
    assign wr_tctl  = bus_req.wr & sel_tctl;
    assign wr_cfg   = bus_req.wr & sel_cfg;
    assign wr_stat  = bus_req.wr & sel_stat;
    assign wr_mask  = bus_req.wr & sel_mask;

    // Write data fields
    assign wr_sel_val  = {bus_req.wdata[EIF_SEL1_POS],  bus_req.wdata[EIF_SEL0_POS]};
    assign wr_pend_val = {bus_req.wdata[EIF_PEND1_POS], bus_req.wdata[EIF_PEND0_POS]};
    assign wr_pol_val  = {bus_req.wdata[EIF_POL1_POS],  bus_req.wdata[EIF_POL0_POS]};
    assign wr_ev_val   = {bus_req.wdata[EIF_EV1_POS],   bus_req.wdata[EIF_EV0_POS]};

    // Per-channel detection and pending flag
    for (genvar i = 0; i < EIF_NUM_CH; i++) begin : g_ch
        eif_sync_edge #(
            .STAGES   (SYNC_STAGES)
        ) u_sync (
            .clk      (clk),
            .resetn   (resetn),
            .raw_in   (raw_in[i]),
            .polarity (pol_reg[i]),
            .active   (act[i]),
            .rise     (rise[i])
        );

        // Software write of zero or vectoring clears an edge-mode flag
        assign pend_clr[i]  = vec_ack[i] | (wr_tctl & ~wr_pend_val[i]);
        // Detected activity wins over a clear in the same cycle
        assign pend_edge[i] = rise[i] | (wr_tctl & wr_pend_val[i])
                            | (pend_reg[i] & ~pend_clr[i]);
        // Level mode tracks the synchronised active level
        assign pend_next[i] = edge_sel_reg[i] ? pend_edge[i] : act[i];
    end

    assign edge_sel_next = wr_tctl ? wr_sel_val : edge_sel_reg;
    assign pol_next      = wr_cfg ? wr_pol_val : pol_reg;
    assign mask_next     = wr_mask ? wr_ev_val : mask_reg;

    // Status records each new pending flag; write one to clear, set wins
    assign pend_ev   = pend_next & ~pend_reg;
    assign stat_clr  = wr_stat ? wr_ev_val : '0;
    assign stat_next = pend_ev | (stat_reg & ~stat_clr);
    assign irq_next  = |(stat_next & mask_next);

    // Read views; timer bits of the control register read as zero here
    assign tctl_view = {4'h0, pend_reg[1], edge_sel_reg[1], pend_reg[0], edge_sel_reg[0]};
    assign cfg_view  = {6'h00, pol_reg};
    assign stat_view = {6'h00, stat_reg};
    assign mask_view = {6'h00, mask_reg};
    assign rd_mux    = sel_tctl ? tctl_view :
                       sel_cfg  ? cfg_view  :
                       sel_stat ? stat_view :
                       sel_mask ? mask_view : EIF_RD_IDLE;
    assign rd_data_next = bus_req.rd ? rd_mux : EIF_RD_IDLE;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            edge_sel_reg <= EIF_TCTL_RST[EIF_NUM_CH-1:0];
            pend_reg     <= EIF_TCTL_RST[EIF_NUM_CH-1:0];
            pol_reg      <= EIF_CFG_RST[EIF_NUM_CH-1:0];
        end else begin
            edge_sel_reg <= edge_sel_next;
            pend_reg     <= pend_next;
            pol_reg      <= pol_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat_reg    <= EIF_STAT_RST[EIF_NUM_CH-1:0];
            mask_reg    <= EIF_MASK_RST[EIF_NUM_CH-1:0];
            irq_reg     <= 1'b0;
            rd_data_reg <= EIF_RD_IDLE;
        end else begin
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
            irq_reg     <= irq_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data          = rd_data_reg;
    assign ext_irq0_pending = pend_reg[0];
    assign ext_irq1_pending = pend_reg[1];
    assign irq              = irq_reg;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    localparam int LAT = SYNC_STAGES + 1;

    edge0_set_a: assert property (
        edge_sel_reg[0] && rise[0] |=> pend_reg[0]
    ) else $error("channel 0 edge did not set its flag");

    edge1_set_a: assert property (
        edge_sel_reg[1] && rise[1] |=> pend_reg[1]
    ) else $error("channel 1 edge did not set its flag");

    vec0_clear_a: assert property (
        edge_sel_reg[0] && vec_ack[0] && !rise[0] && !wr_tctl |=> !pend_reg[0]
    ) else $error("channel 0 vectoring did not clear its flag");

    sw0_clear_a: assert property (
        edge_sel_reg[0] && wr_tctl && !wr_pend_val[0] && !rise[0] |=> !pend_reg[0]
    ) else $error("channel 0 software clear failed");

    lvl0_follow_a: assert property (
        !edge_sel_reg[0] |=> pend_reg[0] == $past(act[0])
    ) else $error("channel 0 level flag does not follow input");

    vec1_clear_a: assert property (
        edge_sel_reg[1] && vec_ack[1] && !rise[1] && !wr_tctl |=> !pend_reg[1]
    ) else $error("channel 1 vectoring did not clear its flag");

    lvl1_follow_a: assert property (
        !edge_sel_reg[1] |=> pend_reg[1] == $past(act[1])
    ) else $error("channel 1 level flag does not follow input");

    edge_hold_a: assert property (
        edge_sel_reg[0] && pend_reg[0] && !vec_ack[0] && !wr_tctl |=> pend_reg[0]
    ) else $error("edge mode flag dropped without a clear");

    sel_write_a: assert property (
        wr_tctl |=> edge_sel_reg == $past(wr_sel_val)
    ) else $error("trigger select not written");

    pol_sync_a: assert property (
        act[0] == ($past(pol_reg[0]) ? $past(raw_in[0], LAT) : !$past(raw_in[0], LAT))
    ) else $error("channel 0 active level wrong for its polarity");

    sync_delay_a: assert property (
        $rose(raw_in[1]) && pol_reg[1] ##1 pol_reg[1] [*2] |-> ##1 act[1]
    ) else $error("channel 1 input not seen after synchroniser");

    stat_set_a: assert property (
        $rose(pend_reg[0]) |-> stat_reg[0] ##1 (stat_reg[0] || $past(wr_stat))
    ) else $error("status did not record a new flag");

    irq_gate_a: assert property (
        stat_reg == '0 |-> !irq_reg
    ) else $error("interrupt raised with empty status");

    rd_stat_a: assert property (
        bus_req.rd && sel_stat |=> rd_data == {6'h00, $past(stat_reg)}
    ) else $error("status read returned wrong data");

    // Channel 1 counterparts, the quiet cases of the flag logic and the channel 0 software set
    sw1_clear_a: assert property (
        edge_sel_reg[1] && wr_tctl && !wr_pend_val[1] && !rise[1] |=> !pend_reg[1]
    ) else $error("channel 1 software clear failed");

    edge1_hold_a: assert property (
        edge_sel_reg[1] && pend_reg[1] && !vec_ack[1] && !wr_tctl |=> pend_reg[1]
    ) else $error("channel 1 edge mode flag dropped without a clear");

    edge0_quiet_a: assert property (
        edge_sel_reg[0] && !pend_reg[0] && !rise[0] && !wr_tctl |=> !pend_reg[0]
    ) else $error("channel 0 flag set without an edge");

    edge1_quiet_a: assert property (
        edge_sel_reg[1] && !pend_reg[1] && !rise[1] && !wr_tctl |=> !pend_reg[1]
    ) else $error("channel 1 flag set without an edge");

    sw0_set_a: assert property (
        edge_sel_reg[0] && wr_tctl && wr_pend_val[0] |=> pend_reg[0]
    ) else $error("channel 0 software set failed");

    vec0_level_a: assert property (
        !edge_sel_reg[0] && vec_ack[0] && act[0] |=> pend_reg[0]
    ) else $error("vectoring cleared a channel 0 level flag");

    vec1_level_a: assert property (
        !edge_sel_reg[1] && vec_ack[1] && act[1] |=> pend_reg[1]
    ) else $error("vectoring cleared a channel 1 level flag");

    // The active level lags the pin by the synchroniser and one register
    pol1_sync_a: assert property (
        act[1] == ($past(pol_reg[1]) ? $past(raw_in[1], LAT) : !$past(raw_in[1], LAT))
    ) else $error("channel 1 active level wrong for its polarity");

    sync0_delay_a: assert property (
        $fell(raw_in[0]) && !pol_reg[0] ##1 (!pol_reg[0]) [*2] |-> ##1 act[0]
    ) else $error("channel 0 input not seen after synchroniser");

    // Configuration registers change only when written
    sel_hold_a: assert property (
        !wr_tctl |=> $stable(edge_sel_reg)
    ) else $error("trigger select changed without a write");

    pol_write_a: assert property (
        wr_cfg |=> pol_reg == $past(wr_pol_val)
    ) else $error("polarity not written");

    pol_hold_a: assert property (
        !wr_cfg |=> $stable(pol_reg)
    ) else $error("polarity changed without a write");

    mask_write_a: assert property (
        wr_mask |=> mask_reg == $past(wr_ev_val)
    ) else $error("mask not written");

    mask_hold_a: assert property (
        !wr_mask |=> $stable(mask_reg)
    ) else $error("mask changed without a write");

    // Status is sticky, cleared by a one, and set only by a new flag
    stat_clear_a: assert property (
        wr_stat && wr_ev_val[0] && !pend_ev[0] |=> !stat_reg[0]
    ) else $error("status write of one did not clear");

    stat_hold_a: assert property (
        stat_reg[1] && !wr_stat |=> stat_reg[1]
    ) else $error("status bit dropped without a clear");

    stat_set1_a: assert property (
        $rose(pend_reg[1]) |-> stat_reg[1]
    ) else $error("status did not record a new channel 1 flag");

    stat_cause_a: assert property (
        $rose(stat_reg[0]) |-> $rose(pend_reg[0])
    ) else $error("status set without a new flag");

    irq_level_a: assert property (
        irq_reg == (|(stat_reg & mask_reg))
    ) else $error("interrupt output does not match status and mask");

    // Read data stand one cycle after the strobe and read zero otherwise
    rd_idle_a: assert property (
        !bus_req.rd |=> rd_data == EIF_RD_IDLE
    ) else $error("read data not idle without a read");

    rd_tctl_a: assert property (
        bus_req.rd && sel_tctl |=> rd_data[7:4] == 4'h0
            && rd_data[EIF_SEL0_POS] == $past(edge_sel_reg[0])
            && rd_data[EIF_PEND0_POS] == $past(pend_reg[0])
            && rd_data[EIF_SEL1_POS] == $past(edge_sel_reg[1])
            && rd_data[EIF_PEND1_POS] == $past(pend_reg[1])
    ) else $error("control read returned wrong data");

    rd_cfg_a: assert property (
        bus_req.rd && sel_cfg |=> rd_data == {6'h00, $past(pol_reg)}
    ) else $error("config read returned wrong data");

    rd_mask_a: assert property (
        bus_req.rd && sel_mask |=> rd_data == {6'h00, $past(mask_reg)}
    ) else $error("mask read returned wrong data");

    rd_unmapped_a: assert property (
        bus_req.rd && !(sel_tctl || sel_cfg || sel_stat || sel_mask) |=> rd_data == EIF_RD_IDLE
    ) else $error("unmapped read returned data");

    edge_seen_c:  cover property (edge_sel_reg[0] && rise[0] ##1 pend_reg[0]);
    vec_clear_c:  cover property (pend_reg[1] && vec_ack[1] ##1 !pend_reg[1]);
    lvl_follow_c: cover property (!edge_sel_reg[0] && pend_reg[0] ##[1:20] !pend_reg[0]);
    irq_rise_c:   cover property ($rose(irq_reg));
    sw_set_c:     cover property (edge_sel_reg[0] && wr_tctl && wr_pend_val[0] ##1 pend_reg[0]);

endmodule // eif_top
`default_nettype wire

/* verification/eif_pin_model.sv */
// Model of the outside circuit that drives the two interrupt pins
`timescale 1ns/1ps
`default_nettype none
module eif_pin_model (
    input  wire logic clk,
    input  wire logic want0,
    input  wire logic want1,
    output logic      pin0,
    output logic      pin1
);
    // Pins move one edge after the request and sit idle high from time zero
    logic pin0_reg = 1'b1;
    logic pin1_reg = 1'b1;
    always @(posedge clk) begin
        pin0_reg <= want0;
        pin1_reg <= want1;
    end
    assign pin0 = pin0_reg;
    assign pin1 = pin1_reg;
endmodule // eif_pin_model
`default_nettype wire

/* verification/eif_top_tb.sv */
// Register-level testbench of the external interrupt flags
`timescale 1ns/1ps
`default_nettype none
module eif_top_tb;
    import eif_pkg::*;
    logic                  clk = 1'b0;
    logic                  resetn = 1'b0;
    eif_bus_req_t          bus_req = '0;
    logic [EIF_DATA_W-1:0] rd_data;
    logic                  want0 = 1'b1;
    logic                  want1 = 1'b1;
    logic                  pin0;
    logic                  pin1;
    logic                  va0 = 1'b0;
    logic                  va1 = 1'b0;
    logic                  pend0;
    logic                  pend1;
    logic                  irq;
    int                    fails = 0;
    int                    n_compared = 0;

    always #50 clk = ~clk;

    eif_pin_model eif_pin_model_inst (.clk(clk), .want0(want0), .want1(want1),
        .pin0(pin0), .pin1(pin1));
    eif_top eif_top_inst (.clk(clk), .resetn(resetn), .bus_req(bus_req),
        .rd_data(rd_data), .ext_irq0_input(pin0), .ext_irq1_input(pin1),
        .vector_ack0(va0), .vector_ack1(va1), .ext_irq0_pending(pend0),
        .ext_irq1_pending(pend1), .irq(irq));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 check(rd_data, exp);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic ack(input int ch);
        @(posedge clk);
        if (ch == 0) va0 <= 1'b1; else va1 <= 1'b1;
        @(posedge clk);
        va0 <= 1'b0;
        va1 <= 1'b0;
        wait_n(1);
    endtask
    task automatic pins(input logic p0, input logic p1);
        @(posedge clk);
        want0 <= p0;
        want1 <= p1;
    endtask
    task automatic flags(input logic e0, input logic e1);
        check({7'h00, pend0}, {7'h00, e0});
        check({7'h00, pend1}, {7'h00, e1});
    endtask
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #500000;
        fails++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        // Reset values and an unmapped address
        rd_chk(EIF_TCTL_OFS, 8'h00);
        rd_chk(EIF_CFG_OFS, 8'h00);
        rd_chk(EIF_STAT_OFS, 8'h00);
        rd_chk(EIF_MASK_OFS, 8'h00);
        rd_chk(4'h7, 8'h00);
        flags(1'b0, 1'b0);
        $display("test reset done");
        // Channel 0 edge, active low; upper control bits read zero
        wr(EIF_TCTL_OFS, 8'hf1);
        rd_chk(EIF_TCTL_OFS, 8'h01);
        pins(1'b0, 1'b1);
        wait_n(2);
        flags(1'b0, 1'b0);
        wait_n(5);
        flags(1'b1, 1'b0);
        rd_chk(EIF_TCTL_OFS, 8'h03);
        rd_chk(EIF_STAT_OFS, 8'h01);
        check({7'h00, irq}, 8'h00);
        wr(EIF_MASK_OFS, 8'h01);
        wait_n(2);
        check({7'h00, irq}, 8'h01);
        ack(0);
        flags(1'b0, 1'b0);
        wait_n(5);
        flags(1'b0, 1'b0);
        wr(EIF_STAT_OFS, 8'h01);
        wait_n(2);
        check({7'h00, irq}, 8'h00);
        $display("test edge0 done");
        // Channel 1 level then edge, polarity switched to active high
        pins(1'b0, 1'b0);
        wait_n(7);
        flags(1'b0, 1'b1);
        wr(EIF_CFG_OFS, 8'h02);
        wait_n(6);
        flags(1'b0, 1'b0);
        wr(EIF_TCTL_OFS, 8'h05);
        pins(1'b0, 1'b1);
        wait_n(7);
        flags(1'b0, 1'b1);
        wr(EIF_TCTL_OFS, 8'h05);
        wait_n(1);
        flags(1'b0, 1'b0);
        pins(1'b0, 1'b0);
        wait_n(3);
        pins(1'b0, 1'b1);
        wait_n(7);
        flags(1'b0, 1'b1);
        ack(1);
        flags(1'b0, 1'b0);
        wr(EIF_STAT_OFS, 8'h03);
        rd_chk(EIF_STAT_OFS, 8'h00);
        $display("test edge1 done");
        // Channel 0 level: vectoring and writes leave the flag alone
        wr(EIF_TCTL_OFS, 8'h04);
        wait_n(3);
        flags(1'b1, 1'b0);
        ack(0);
        flags(1'b1, 1'b0);
        wr(EIF_TCTL_OFS, 8'h04);
        wait_n(1);
        flags(1'b1, 1'b0);
        pins(1'b1, 1'b1);
        wait_n(7);
        flags(1'b0, 1'b0);
        $display("test level0 done");
        // Software set in edge mode, read data standing one cycle, channel 1 interrupt
        wr(EIF_TCTL_OFS, 8'h05);
        wr(EIF_STAT_OFS, 8'h03);
        wr(EIF_MASK_OFS, 8'h02);
        wr(EIF_TCTL_OFS, 8'h0f);
        wait_n(2);
        flags(1'b1, 1'b1);
        check({7'h00, irq}, 8'h01);
        rd_chk(EIF_TCTL_OFS, 8'h0f);
        wait_n(1);
        check(rd_data, 8'h00);
        rd_chk(EIF_STAT_OFS, 8'h03);
        $display("test soft set done");
        print_verdict();
    end
endmodule // eif_top_tb
`default_nettype wire
